// ==== src/hiss_pkg.sv ====
// package with constants and types for the host interface front end
package hiss_pkg;
    // host protocol chosen by the two select inputs
    typedef enum logic [1:0] {
        HISS_SPI4,
        HISS_SPI3,
        HISS_P68,
        HISS_P80
    } hiss_proto_t;
    // bit positions of serial pins on the host data bus
    localparam int SCLK_BIT = 0;
    localparam int SERIAL_IN_BIT = 1;
    // bits in a serial byte, and in a three-wire word with leading d/c bit
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] WORD3_BITS = 4'h9;
    // frame trigger period in clock cycles (arbitrary divider)
    localparam int FRAME_DIV = 40000;
    // depth of the output buffer
    localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage

// ==== src/hiss_host_if.sv ====
// host interface front end: protocol select, strobes, byte steering
// Function
// - select pins choose serial or parallel protocol
// - reset low initialises controller and driver
// - bus ignored unless chip select low
// - parallel byte: d/c high data, low command
// - serial byte: d/c high data, low command (pin in four-wire, leading bit in three-wire)
// - frame trigger out on unconnected test pad
// - serial data on bit 1, clock bit 0
// - 80-style: read/write on strobe low
// - 68-style: enable high, r/w selects direction
`timescale 1ns/1ps
module hiss_host_if #(
    parameter int FRAME_CYCLES = hiss_pkg::FRAME_DIV
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic proto_sel_lo,
    input wire logic proto_sel_hi,
    input wire logic cs_n,
    input wire logic dc_in,
    input wire logic rw_wr_n,
    input wire logic en_rd_n,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe,
    input wire logic [7:0] rd_data,
    output logic rd_req,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_byte,
    output logic out_is_data,
    output logic init_busy,
    output logic frame_trigger_out
);
    // three-stage synchronisers for all pins
    logic [2:0] cs_s, dc_s, rw_s, en_s, sclk_s, ser_in_s;
    logic [2:0] sel_lo_s, sel_hi_s; // select pins, settle during reset
    logic [7:0] d1_q, d2_q, d3_q;
    // last agreed level of the filtered d/c, r/w, enable and serial data pins
    logic dc_h_q, rw_h_q, en_h_q, ser_in_h_q;
    // sampled protocol, fixed until next reset
    hiss_pkg::hiss_proto_t proto_q;
    logic proto_ok_q;
    // serial shift state
    logic [8:0] shreg_q;
    logic [3:0] bitcnt_q;
    // strobe edge tracking (filtered levels)
    logic wr_lvl_q, rd_lvl_q, sclk_lvl_q;
    // produced word towards buffer
    logic push;
    logic [7:0] push_byte;
    logic push_dc;
    // two-entry buffer storage
    logic [7:0] buf_byte [2];
    logic buf_dc [2];
    logic [1:0] count_q;
    logic wptr_q, rptr_q;
    logic [31:0] frame_cnt_q; // frame trigger divider

    // filtered level: follows the pin once stages two and three agree
    function automatic logic agreed(input logic [2:0] s, input logic held);
        agreed = (s[1] == s[2]) ? s[2] : held;
    endfunction

    // filtered levels: second and third stage agree
    logic cs_act, dc_f, rw_f, en_f, sclk_f, ser_in_f;
    assign cs_act = (cs_s[1] == cs_s[2]) ? !cs_s[2] : 1'b0;
    assign dc_f = agreed(dc_s, dc_h_q);
    assign rw_f = agreed(rw_s, rw_h_q);
    assign en_f = agreed(en_s, en_h_q);
    assign sclk_f = agreed(sclk_s, sclk_lvl_q);
    assign ser_in_f = agreed(ser_in_s, ser_in_h_q);

    // synchroniser chains
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_s <= 3'h7;
            dc_s <= 3'h0;
            rw_s <= 3'h7;
            en_s <= 3'h7;
            sclk_s <= 3'h0;
            ser_in_s <= 3'h0;
            d1_q <= 8'h00;
            d2_q <= 8'h00;
            d3_q <= 8'h00;
        end else begin
            cs_s <= {cs_s[1:0], cs_n};
            dc_s <= {dc_s[1:0], dc_in};
            rw_s <= {rw_s[1:0], rw_wr_n};
            en_s <= {en_s[1:0], en_rd_n};
            sclk_s <= {sclk_s[1:0],
                       host_data_bus_i[hiss_pkg::SCLK_BIT]};
            ser_in_s <= {ser_in_s[1:0],
                         host_data_bus_i[hiss_pkg::SERIAL_IN_BIT]};
            d1_q <= host_data_bus_i;
            d2_q <= d1_q;
            d3_q <= d2_q;
        end
    end

    // agreed levels held while the synchroniser stages disagree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dc_h_q <= 1'b0;
            rw_h_q <= 1'b1;
            en_h_q <= 1'b1;
            ser_in_h_q <= 1'b0;
        end else begin
            dc_h_q <= dc_f;
            rw_h_q <= rw_f;
            en_h_q <= en_f;
            ser_in_h_q <= ser_in_f;
        end
    end

    // select synchronisers run without reset, so they settle while reset
    // is held; reset must therefore last at least three clocks
    always_ff @(posedge clk) begin
        sel_lo_s <= {sel_lo_s[1:0], proto_sel_lo};
        sel_hi_s <= {sel_hi_s[1:0], proto_sel_hi};
    end

    // protocol capture on first cycle after reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            proto_q <= hiss_pkg::HISS_SPI4;
            proto_ok_q <= 1'b0;
        end else if (!proto_ok_q) begin
            proto_ok_q <= 1'b1;
            case ({sel_lo_s[2], sel_hi_s[2]})
                2'b10: proto_q <= hiss_pkg::HISS_SPI3;
                2'b00: proto_q <= hiss_pkg::HISS_SPI4;
                2'b11: proto_q <= hiss_pkg::HISS_P68;
                default: proto_q <= hiss_pkg::HISS_P80;
            endcase
        end
    end

    // initialisation flag: high while reset or protocol not captured
    assign init_busy = !proto_ok_q;

    logic serial;
    assign serial = (proto_q == hiss_pkg::HISS_SPI3) ||
                    (proto_q == hiss_pkg::HISS_SPI4);

    // write and read strobe activity per parallel mode
    logic wr_act, rd_act;
    always_comb begin
        wr_act = 1'b0;
        rd_act = 1'b0;
        case (proto_q)
            hiss_pkg::HISS_P80: begin
                wr_act = cs_act && !rw_f;
                rd_act = cs_act && !en_f;
            end
            hiss_pkg::HISS_P68: begin
                wr_act = cs_act && en_f && !rw_f;
                rd_act = cs_act && en_f && rw_f;
            end
            default: begin
                wr_act = 1'b0;
                rd_act = 1'b0;
            end
        endcase
    end

    // strobe level history for edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_lvl_q <= 1'b0;
            rd_lvl_q <= 1'b0;
            sclk_lvl_q <= 1'b0;
        end else begin
            wr_lvl_q <= wr_act && proto_ok_q;
            rd_lvl_q <= rd_act && proto_ok_q;
            sclk_lvl_q <= sclk_f;
        end
    end

    // serial receiver: shift on rising serial clock while selected
    logic sclk_rise;
    logic [3:0] need_bits;
    assign sclk_rise = sclk_f && !sclk_lvl_q;
    assign need_bits = (proto_q == hiss_pkg::HISS_SPI3) ?
                       hiss_pkg::WORD3_BITS : hiss_pkg::BYTE_BITS;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shreg_q <= 9'h000;
            bitcnt_q <= 4'h0;
        end else if (!serial || !cs_act || !proto_ok_q) begin
            bitcnt_q <= 4'h0; // deselect aborts a partial word
        end else if (sclk_rise) begin
            shreg_q <= {shreg_q[7:0], ser_in_f};
            bitcnt_q <= (bitcnt_q + 4'h1 == need_bits) ? 4'h0 :
                        bitcnt_q + 4'h1;
        end
    end

    // word completion: push a byte with its data/command tag
    logic ser_done;
    assign ser_done = serial && cs_act && proto_ok_q && sclk_rise &&
                      (bitcnt_q + 4'h1 == need_bits);
    always_comb begin
        push = 1'b0;
        push_byte = d3_q;
        push_dc = dc_f;
        if (ser_done) begin
            push = 1'b1;
            push_byte = {shreg_q[6:0], ser_in_f};
            if (proto_q == hiss_pkg::HISS_SPI3) begin
                push_dc = shreg_q[7];
            end else begin
                push_dc = dc_f;
            end
        end else if (!serial && wr_lvl_q && !(wr_act && proto_ok_q)) begin
            push = 1'b1; // byte latched at end of write strobe
            push_byte = d3_q;
            push_dc = dc_f;
        end
    end

    // two-entry buffer; a push while full is dropped (host too fast)
    logic do_push, do_pop;
    assign do_push = push && (count_q != hiss_pkg::BUF_DEPTH);
    assign do_pop = out_valid && out_ready;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 2'h0;
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
        end else begin
            if (do_push) begin
                wptr_q <= !wptr_q;
            end
            if (do_pop) begin
                rptr_q <= !rptr_q;
            end
            count_q <= count_q + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

    // buffer storage write
    always_ff @(posedge clk) begin
        if (do_push) begin
            buf_byte[wptr_q] <= push_byte;
            buf_dc[wptr_q] <= push_dc;
        end
    end

    assign out_valid = (count_q != 2'h0);
    assign out_byte = out_valid ? buf_byte[rptr_q] : 8'h00;
    assign out_is_data = out_valid ? buf_dc[rptr_q] : 1'b0;

    // read path: request on read start, drive bus while read active
    assign rd_req = rd_act && proto_ok_q && !rd_lvl_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            host_data_bus_o <= 8'h00;
            host_data_bus_oe <= 1'b0;
        end else begin
            host_data_bus_o <= rd_data;
            host_data_bus_oe <= rd_act && proto_ok_q && !serial;
        end
    end

    // frame trigger: free divider toggling the test pad output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            frame_cnt_q <= 32'h0;
            frame_trigger_out <= 1'b0;
        end else if (frame_cnt_q == 32'(FRAME_CYCLES - 1)) begin
            frame_cnt_q <= 32'h0;
            frame_trigger_out <= !frame_trigger_out;
        end else begin
            frame_cnt_q <= frame_cnt_q + 32'h1;
        end
    end
endmodule // hiss_host_if

// ==== tb/hiss_checker.sv ====
// checker for the host interface front end
`timescale 1ns/1ps
module hiss_checker #(
    parameter int FRAME_CYCLES = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic rd_req,
    input wire logic host_data_bus_oe,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_byte,
    input wire logic out_is_data,
    input wire logic init_busy,
    input wire logic frame_trigger_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // deselected long enough to pass the synchroniser
    sequence cs_idle_s; cs_n [*6]; endsequence
    // trigger quiet for seven cycles, then toggles (period of 8)
    sequence frame_run_s;
        (!$changed(frame_trigger_out)) [*7] ##1 $changed(frame_trigger_out);
    endsequence
    reset_quiet_a: assert property ($rose(resetn) |->
        !out_valid && !host_data_bus_oe) else $error("busy after reset");
    busy_drop_a: assert property ($rose(resetn) |-> ##2 !init_busy)
        else $error("init stays busy");
    cs_noreq_a: assert property (cs_idle_s |-> !rd_req)
        else $error("read request while deselected");
    cs_nooe_a: assert property (cs_idle_s |-> !host_data_bus_oe)
        else $error("bus driven while deselected");
    cs_nopush_a: assert property (cs_idle_s ##0 !out_valid |=>
        !out_valid) else $error("byte taken while deselected");
    req_pulse_a: assert property (rd_req |=>
        !rd_req && host_data_bus_oe) else $error("read answer wrong");
    hold_out_a: assert property (out_valid && !out_ready |=>
        out_valid && $stable({out_is_data, out_byte}))
        else $error("stalled byte changed");
    frame_period_a: assert property ($changed(frame_trigger_out) |=>
        frame_run_s) else $error("frame trigger period wrong");
endmodule // hiss_checker
bind hiss_host_if hiss_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
    .clk(clk), .resetn(resetn), .cs_n(cs_n), .rd_req(rd_req),
    .host_data_bus_oe(host_data_bus_oe), .out_valid(out_valid),
    .out_ready(out_ready), .out_byte(out_byte), .out_is_data(out_is_data),
    .init_busy(init_busy), .frame_trigger_out(frame_trigger_out));

// ==== tb/hiss_host_model.sv ====
// host model driving chip select, strobes and data pins
`timescale 1ns/1ps
module hiss_host_model (
    input wire logic clk,
    input wire logic [7:0] bus_o,
    input wire logic bus_oe,
    output logic cs_n,
    output logic dc_in,
    output logic rw_wr_n,
    output logic en_rd_n,
    output logic [7:0] bus_i
);
    logic [8:0] seen; // drive enable and read byte seen during a read
    // deselect and park strobes for mode m (3 = 80-style, idle high)
    task automatic park(input logic [1:0] m);
        cs_n <= 1'b1;
        dc_in <= 1'b0;
        bus_i <= 8'h00;
        rw_wr_n <= (m == 2'h3);
        en_rd_n <= (m == 2'h3);
    endtask
    // one word; m 0/1 serial 8/9 bits, 2 68-style, 3 80-style; r reads
    task automatic send(input logic [1:0] m, input logic c, d, r,
                        input logic [8:0] w);
        cs_n <= c;
        dc_in <= d;
        if (m[1]) begin
            bus_i <= w[7:0];
            repeat (6) @(posedge clk);
            en_rd_n <= en_rd_n ^ (!m[0] | r);
            // 68: r/w goes high for a read; 80: write strobe goes low
            rw_wr_n <= rw_wr_n ^ (m[0] ^ r);
            repeat (8) @(posedge clk);
            seen = {bus_oe, bus_o};
            en_rd_n <= en_rd_n ^ (!m[0] | r);
            rw_wr_n <= rw_wr_n ^ (m[0] ^ r);
        end else begin
            // msb first, data set up while the clock is low
            for (int i = 7 + m[0]; i >= 0; i--) begin
                bus_i <= {6'h00, w[i], 1'b0};
                repeat (5) @(posedge clk);
                bus_i[0] <= 1'b1;
                repeat (5) @(posedge clk);
            end
        end
        repeat (6) @(posedge clk);
        // released lines show the inverse of their last value
        bus_i <= m[1] ? ~bus_i : {6'h00, ~bus_i[1], 1'b0};
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
endmodule // hiss_host_model

// ==== tb/testbench.sv ====
// self-checking bench for the host interface front end
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn, sel_lo, sel_hi, out_ready, cs_n, dc, rw, en, oe;
    logic rd_req, out_valid, is_data, busy, frame;
    logic [7:0] rd_data, bus_h, bus_o, ob;
    int miscompares = 0, checks_done = 0, cycles = 0;
    initial forever #12.5 clk = ~clk;
    hiss_host_if #(.FRAME_CYCLES(8)) dut (
        .clk(clk), .resetn(resetn), .proto_sel_lo(sel_lo),
        .proto_sel_hi(sel_hi), .cs_n(cs_n), .dc_in(dc), .rw_wr_n(rw),
        .en_rd_n(en), .host_data_bus_i(oe ? bus_o : bus_h),
        .host_data_bus_o(bus_o), .host_data_bus_oe(oe),
        .rd_data(rd_data), .rd_req(rd_req), .out_valid(out_valid),
        .out_ready(out_ready), .out_byte(ob), .out_is_data(is_data),
        .init_busy(busy), .frame_trigger_out(frame));
    hiss_host_model host (.clk(clk), .bus_o(bus_o), .bus_oe(oe),
        .cs_n(cs_n), .dc_in(dc), .rw_wr_n(rw), .en_rd_n(en), .bus_i(bus_h));
    task automatic chk(input logic [8:0] e, input logic [8:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // wait for a buffered byte, compare it with its flag, accept it
    task automatic pop(input logic [8:0] e);
        int n = 0;
        #1;
        while (out_valid !== 1'b1 && n < 60) begin
            @(posedge clk) #1;
            n++;
        end
        chk(e, {is_data, ob});
        @(posedge clk) out_ready <= 1'b1;
        @(posedge clk) out_ready <= 1'b0;
    endtask
    // reset with mode m selected: 0 four-wire, 1 three-wire, 2 68, 3 80
    task automatic mode(input logic [1:0] m);
        resetn <= 1'b0;
        sel_lo <= m[0] ^ m[1];
        sel_hi <= m[1];
        host.park(m);
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // steering, a deselected write, an overfull buffer, a read
    task automatic t_p80();
        mode(2'h3);
        host.send(2'h3, 1'b0, 1'b1, 1'b0, 9'h0a5);
        pop(9'h1a5);
        host.send(2'h3, 1'b1, 1'b1, 1'b0, 9'h05a);
        #1 chk(9'h000, {8'h00, out_valid});
        @(posedge clk);
        host.send(2'h3, 1'b0, 1'b0, 1'b0, 9'h03c);
        host.send(2'h3, 1'b0, 1'b1, 1'b0, 9'h0c3);
        host.send(2'h3, 1'b0, 1'b1, 1'b0, 9'h077);
        pop(9'h03c);
        pop(9'h1c3);
        #1 chk(9'h000, {8'h00, out_valid});
        @(posedge clk);
        host.send(2'h3, 1'b0, 1'b0, 1'b1, 9'h000);
        chk(9'h196, host.seen);
        $display("test 80-style done");
    endtask
    task automatic t_p68();
        mode(2'h2);
        // selects moved after capture must leave the protocol alone
        sel_lo <= 1'b0;
        sel_hi <= 1'b0;
        host.send(2'h2, 1'b0, 1'b1, 1'b0, 9'h0e1);
        pop(9'h1e1);
        host.send(2'h2, 1'b0, 1'b0, 1'b0, 9'h01e);
        pop(9'h01e);
        host.send(2'h2, 1'b0, 1'b0, 1'b1, 9'h000);
        chk(9'h196, host.seen);
        $display("test 68-style done");
    endtask
    task automatic t_spi4();
        mode(2'h0);
        host.send(2'h0, 1'b0, 1'b1, 1'b0, 9'h0b4);
        pop(9'h1b4);
        host.send(2'h0, 1'b0, 1'b0, 1'b0, 9'h0d2);
        pop(9'h0d2);
        $display("test four-wire done");
    endtask
    task automatic t_spi3();
        mode(2'h1);
        host.send(2'h1, 1'b0, 1'b0, 1'b0, 9'h169);
        pop(9'h169);
        host.send(2'h1, 1'b0, 1'b0, 1'b0, 9'h096);
        pop(9'h096);
        $display("test three-wire done");
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        resetn = 1'b0;
        sel_lo = 1'b0;
        sel_hi = 1'b1;
        out_ready = 1'b0;
        rd_data = 8'h96;
        host.park(2'h3);
        @(posedge clk);
        t_p80();
        t_p68();
        t_spi4();
        t_spi3();
        report_and_stop();
    end
endmodule // testbench
